// File: common/isadec_cfg.svh
// address decoder constants for the isa digital i/o card
`ifndef ISADEC_CFG_SVH
`define ISADEC_CFG_SVH
`define ISADEC_ADDR_W      10
`define ISADEC_BASE_MSB    9
`define ISADEC_BASE_LSB    4
`define ISADEC_FULL_LSB    5
`define ISADEC_SW_W        6
`define ISADEC_FULL_SPAN   32
`define ISADEC_HALF_SPAN   16
`define ISADEC_FULL_LINES  144
`define ISADEC_HALF_LINES  96
`define ISADEC_RANGE_LO    10'h200
`define ISADEC_RANGE_HI    10'h3FF
`endif

// File: common/isadec_pkg.sv
// types shared by the isa address decoder
package isadec_pkg;
  typedef enum logic [1:0] {
    ISADEC_IDLE = 2'b00,
    ISADEC_SEL  = 2'b01,
    ISADEC_HOLD = 2'b11
  } isadec_state_t;
endpackage

// File: design/isadec_sync.sv
// two-flop synchroniser bank for asynchronous bus and switch inputs
`timescale 1ns/1ps
`default_nettype none
module isadec_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // a bank needs at least one bit
  if (W < 1) begin : g_bad_width
    $error("isadec_sync: width must be at least one");
  end

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  // first stage feeds only the second
  always_comb begin
    next_stage1   = clk_en ? async_in : stage1;
    next_sync_out = clk_en ? stage1 : sync_out;
  end

  // register both stages
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// File: design/isadec_top.sv
// i/o address decoder for an isa digital i/o add-in card
`timescale 1ns/1ps
`default_nettype none
`include "isadec_cfg.svh"
module isadec_top
  import isadec_pkg::*;
#(
  parameter int ADDR_W = `ISADEC_ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] sa,
  input  wire logic              aen,
  input  wire logic              iorc_n,
  input  wire logic              iowc_n,
  input  wire logic [5:0]        base_address_switch,
  input  wire logic              width_mode_switch,
  output logic                   card_sel,
  output logic                   card_rd,
  output logic                   card_wr,
  output logic [4:0]             card_offset,
  output logic                   full_width,
  output logic                   upper_bank_en
);
  // refuse widths that the fixed a9..a4 decode cannot serve
  if (ADDR_W != `ISADEC_ADDR_W) begin : g_bad_addr_w
    $error("isadec_top: only 10 address bits supported");
  end

  localparam int SYNC_W = ADDR_W + 3 + 6 + 1;
  // idle levels of the bank; flipping by this mask makes the zero reset of the
  // synchroniser show an idle bus in full-width mode instead of a false i/o cycle
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {{ADDR_W{1'b0}}, 3'b111, 6'h00, 1'b1};

  // synchronised views of the bus and switches
  logic [SYNC_W-1:0] sync_bus;
  logic [ADDR_W-1:0] s_addr;
  logic              s_aen;
  logic              s_rd_n;
  logic              s_wr_n;
  logic [5:0]        s_sw;
  logic              s_wide;

  isadec_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in ({sa, aen, iorc_n, iowc_n, base_address_switch, width_mode_switch} ^ SYNC_IDLE),
    .sync_out (sync_bus)
  );
  assign {s_addr, s_aen, s_rd_n, s_wr_n, s_sw, s_wide} = sync_bus ^ SYNC_IDLE;

  // address match against switch settings
  function automatic logic addr_match(input logic [ADDR_W-1:0] a,
                                      input logic [5:0]        sw,
                                      input logic              wide);
    logic [4:0] base;
    base = sw[4:0];                                   // off reads 1, on reads 0 pos 6 unused
    addr_match = a[`ISADEC_BASE_MSB]                   // a9 fixed high
      && (a[8:`ISADEC_FULL_LSB] == base[4:1])          // a8..a5 always compared
      && (wide || (a[`ISADEC_BASE_LSB] == base[0]));   // a4 only in reduced mode
  endfunction

  // decode state and the next values of every register
  isadec_state_t state;
  isadec_state_t next_state;
  logic       next_sel;
  logic       next_rd;
  logic       next_wr;
  logic [4:0] next_offset;
  logic       next_full;
  logic       next_upper;
  logic       io_cycle;
  logic       hit;

  // decode the current cycle
  always_comb begin
    io_cycle = !s_aen && (!s_rd_n || !s_wr_n);          // non-dma i/o only
    hit      = io_cycle && addr_match(s_addr, s_sw, s_wide);
    next_state  = state;
    next_sel    = card_sel;
    next_rd     = card_rd;
    next_wr     = card_wr;
    next_offset = card_offset;
    next_full   = s_wide;
    next_upper  = s_wide;                               // upper 48 lines off in reduced mode
    if (clk_en) begin
      unique case (state)
        ISADEC_IDLE: begin
          if (hit) begin
            next_state = ISADEC_SEL;
          end
        end
        ISADEC_SEL: begin
          if (hit) begin
            next_state = ISADEC_HOLD;
          end else begin
            next_state = ISADEC_IDLE;
          end
        end
        ISADEC_HOLD: begin
          if (!hit) begin
            next_state = ISADEC_IDLE;
          end
        end
        default: next_state = ISADEC_IDLE;
      endcase
      next_sel = hit;
      next_rd  = hit && !s_rd_n;
      next_wr  = hit && !s_wr_n;
      next_offset = s_wide ? s_addr[4:0] : {1'b0, s_addr[3:0]}; // 32 or 16 slots
    end else begin
      next_full  = full_width;
      next_upper = upper_bank_en;
    end
  end

  // register decode outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state         <= ISADEC_IDLE;
      card_sel      <= 1'b0;
      card_rd       <= 1'b0;
      card_wr       <= 1'b0;
      card_offset   <= 5'h00;
      full_width    <= 1'b1;
      upper_bank_en <= 1'b1;
    end else begin
      state         <= next_state;
      card_sel      <= next_sel;
      card_rd       <= next_rd;
      card_wr       <= next_wr;
      card_offset   <= next_offset;
      full_width    <= next_full;
      upper_bank_en <= next_upper;
    end
  end

  // helper views for the checks, rebuilt from the switch wiring
  logic base_hi_ok;
  logic a4_ok;
  assign base_hi_ok = s_addr[`ISADEC_BASE_MSB] && (s_addr[8:`ISADEC_FULL_LSB] == s_sw[4:1]);
  assign a4_ok      = (s_addr[`ISADEC_BASE_LSB] == s_sw[0]);

  // an enabled i/o cycle whose address the switches select
  sequence s_match_cycle;
    clk_en && io_cycle && base_hi_ok && (s_wide || a4_ok);
  endsequence

  // the registered select together with its tracking state
  sequence s_select_up;
    card_sel && (state != ISADEC_IDLE);
  endsequence

  // an enabled cycle that carries no matching i/o cycle
  sequence s_quiet_cycle;
    clk_en && !hit;
  endsequence

  // select only follows a real non-dma i/o cycle
  a_sel_needs_io: assert property (@(posedge core_clk) disable iff (reset)
    $rose(card_sel) |-> $past(io_cycle) && !$past(s_aen))
    else $error("select without i/o cycle");
  a_strobe_qual: assert property (@(posedge core_clk) disable iff (reset)
    card_rd || card_wr |-> card_sel)
    else $error("strobe without select");
  a_rd_from_strobe: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_rd |-> !$past(s_rd_n))
    else $error("read without read strobe");
  a_wr_from_strobe: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_wr |-> !$past(s_wr_n))
    else $error("write without write strobe");
  a_select_held: assert property (@(posedge core_clk) disable iff (reset)
    s_match_cycle ##1 s_match_cycle |=> card_sel && (state == ISADEC_HOLD))
    else $error("held cycle lost select");
  a_select_drop: assert property (@(posedge core_clk) disable iff (reset)
    s_quiet_cycle |=> !card_sel && !card_rd && !card_wr && (state == ISADEC_IDLE))
    else $error("select outlived cycle");

  // base match: a9 high, a8..a5 against the switch, a4 by mode
  a_sel_range: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_sel |-> $past(s_addr[9]))
    else $error("select outside 200-3FF");
  a_sel_base_hi: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_sel |-> $past(s_addr[8:5]) == $past(s_sw[4:1]))
    else $error("select with base mismatch");
  a_a4_reduced: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_sel && !full_width |-> $past(s_addr[4]) == $past(s_sw[0]))
    else $error("reduced mode a4 mismatch");
  a_a4_ignored: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && io_cycle && s_wide && base_hi_ok |=> card_sel)
    else $error("full mode missed a4 alias");
  a_sw6_ignored: assert property (@(posedge core_clk) disable iff (reset)
    s_match_cycle |=> s_select_up)
    else $error("match without sixth position not selected");

  // offset span and enabled lines per mode
  a_offset_width: assert property (@(posedge core_clk) disable iff (reset)
    card_sel && !full_width |-> !card_offset[4])
    else $error("reduced offset beyond 16");
  a_full_span: assert property (@(posedge core_clk) disable iff (reset)
    $past(clk_en) && card_sel && full_width |-> card_offset == $past(s_addr[4:0]))
    else $error("full offset wrong");
  a_upper_lines: assert property (@(posedge core_clk) disable iff (reset)
    upper_bank_en == full_width)
    else $error("line count mismatch");

  // a low clock enable freezes every output
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (reset)
    !clk_en |=> $stable(card_sel) && $stable(card_offset) && $stable(full_width))
    else $error("output moved while frozen");
endmodule
`default_nettype wire

// File: sim/isadec_host.sv
// isa host model issuing single i/o cycles
`timescale 1ns/1ps
`default_nettype none
module isadec_host (
  input  wire logic       core_clk,
  input  wire logic       card_sel,
  input  wire logic       card_rd,
  input  wire logic       card_wr,
  input  wire logic [4:0] card_offset,
  output logic      [9:0] sa,
  output logic            aen,
  output logic            iorc_n,
  output logic            iowc_n
);
  initial begin
    sa = 10'h000;
    aen = 1'b1;
    iorc_n = 1'b1;
    iowc_n = 1'b1;
  end
  // pins change off the edge; the answer is read three edges later
  task automatic io(input logic [9:0] a, input logic w, input logic d,
                    output logic [7:0] seen);
    @(negedge core_clk);
    sa = a;
    aen = d;
    iorc_n = w;
    iowc_n = !w;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    seen = {card_sel, card_rd, card_wr, card_offset};
    @(negedge core_clk);
    iorc_n = 1'b1;
    iowc_n = 1'b1;
    sa = ~a; // released bus no longer shows the address
    aen = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/test_isadec_top.sv
// self-checking bench for the isa i/o address decoder
`timescale 1ns/1ps
`default_nettype none
module test_isadec_top;
  logic        core_clk, reset, en, wide, aen, iorc_n, iowc_n, sel, rd, wr, fw, ub;
  logic [5:0]  sw;
  logic [9:0]  sa;
  logic [4:0]  off;
  logic [7:0]  seen;
  logic [31:0] r;
  logic [9:0]  fa[6] = '{10'h300, 10'h31F, 10'h310, 10'h320, 10'h100, 10'h305};
  logic [9:0]  ra[4] = '{10'h200, 10'h20F, 10'h210, 10'h1FF};
  int          error_cnt = 0;
  int          comparisons = 0;

  isadec_top dut (.core_clk(core_clk), .reset(reset), .clk_en(en), .sa(sa), .aen(aen),
    .iorc_n(iorc_n), .iowc_n(iowc_n), .base_address_switch(sw), .width_mode_switch(wide),
    .card_sel(sel), .card_rd(rd), .card_wr(wr), .card_offset(off), .full_width(fw),
    .upper_bank_en(ub));
  isadec_host host (.core_clk(core_clk), .card_sel(sel), .card_rd(rd), .card_wr(wr),
    .card_offset(off), .sa(sa), .aen(aen), .iorc_n(iorc_n), .iowc_n(iowc_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // watchdog against a hang
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // expected select, strobes and offset for one cycle
  function automatic logic [7:0] exp_io(logic [9:0] a, logic w, logic d);
    logic hit;
    hit = !d && a[9] && a[8:5] == sw[4:1] && (wide || a[4] == sw[0]);
    return {hit, hit && !w, hit && w, wide ? a[4:0] : {1'b0, a[3:0]}};
  endfunction
  task automatic run(input logic [9:0] a, input logic w, input logic d);
    host.io(a, w, d, seen);
    check(seen, exp_io(a, w, d));
    check({7'h00, sel}, 8'h00);
  endtask
  task automatic setsw(input logic [5:0] s, input logic m);
    @(negedge core_clk);
    sw = s;
    wide = m;
    repeat (5) @(negedge core_clk);
    check({6'h00, fw, ub}, {6'h00, m, m});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    sw = 6'h00;
    wide = 1'b1;
    en = 1'b1;
    reset = 1'b1;
    void'($urandom(32'h5B61));
    repeat (2) @(negedge core_clk);
    check({5'h00, sel, fw, ub}, 8'h03);
    reset = 1'b0;
    @(negedge core_clk);
    check({5'h00, sel, fw, ub}, 8'h03);
    setsw(6'h30, 1'b1); // base 300, unused sixth position off
    foreach (fa[i]) run(fa[i], i[0], i == 5);
    $display("test full window done");
    setsw(6'h20, 1'b0);
    foreach (ra[i]) run(ra[i], i[0], 1'b0);
    setsw(6'h21, 1'b0);
    foreach (ra[i]) run(ra[i] + 10'h010, i[0], 1'b0);
    $display("test adjacent blocks done");
    @(negedge core_clk);
    en = 1'b0;
    host.io(10'h210, 1'b0, 1'b0, seen);
    check({5'h00, seen[7:5]}, 8'h00);
    check({6'h00, fw, ub}, 8'h00);
    @(negedge core_clk);
    en = 1'b1;
    $display("test clock enable freeze done");
    for (int n = 0; n < 200; n++) begin
      r = $urandom;
      setsw({r[5:1], r[0] & !(r[6] | r[7])}, r[6] | r[7]);
      run(r[8] ? {1'b1, sw[4:0], r[12:9]} : r[24:15], r[13], r[14] & r[25]);
    end
    $display("test random cycles done");
    report_and_stop();
  end
endmodule
`default_nettype wire
